/* File: pkg/evsel_pkg.sv */
// Shared constants and types of the eight-way value selector
`default_nettype none
package evsel_pkg;
  // ==========================================================================
  // Data path
  localparam int NUM_CH   = 8;   // Number of data inputs
  localparam int CH_MAX   = 7;   // Highest legal channel number
  localparam int CH_MIN   = 0;   // Lowest legal channel number
  localparam int DATA_W   = 32;  // Signed two's-complement value width
  localparam int ADDR_W   = 8;   // Register byte address width

  typedef logic signed [DATA_W-1:0] evsel_word_t;
  typedef logic [NUM_CH-1:0][DATA_W-1:0] evsel_vec_t;

  localparam evsel_word_t WORD_ZERO = 32'h0000_0000;
  localparam evsel_word_t WORD_MIN  = 32'h8000_0000;  // Most negative value

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_VALUE    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CHANNEL  = 8'h14;

  // Field positions and reset values
  localparam int CTRL_CHECK_BIT = 0;      // Activation input is evaluated
  localparam logic CTRL_CHECK_RST = 1'b1;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_ERR_BIT    = 1;
  localparam int IRQ_N       = 2;
  localparam int IRQ_ERR_BIT = 0;         // Range error became present
  localparam int IRQ_CHG_BIT = 1;         // Output value changed
  localparam logic [IRQ_N-1:0] IRQ_MASK_RST = 2'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

/* File: pkg/evsel_sel_if.sv */
// Connection between the register top and the selector core
`default_nettype none
interface evsel_sel_if;
  logic                     cfg_check;  // Activation input is evaluated
  logic                     act;        // Activation level
  evsel_pkg::evsel_word_t   channel;    // Signed channel number
  evsel_pkg::evsel_vec_t    data;       // Eight candidate values
  evsel_pkg::evsel_word_t   value;      // Registered selected value
  logic                     err;        // Registered range error
  logic                     active;     // Registered effective activation

  modport core (input cfg_check, act, channel, data, output value, err, active);
  modport ctrl (output cfg_check, act, channel, data, input value, err, active);
endinterface
`default_nettype wire

/* File: rtl/evsel_sel_core.sv */
// Selector core: channel decode, range check and registered output
`default_nettype none
module evsel_sel_core (
  input wire logic   sys_clk_in,
  input wire logic   rst_in,
  evsel_sel_if.core  sel
);
  // ==========================================================================
  // Decode
  logic [evsel_pkg::NUM_CH-1:0]  hit;
  evsel_pkg::evsel_word_t        term [evsel_pkg::NUM_CH];
  evsel_pkg::evsel_word_t        pick;
  evsel_pkg::evsel_word_t        value_reg;
  evsel_pkg::evsel_word_t        value_next;
  logic                          err_reg;
  logic                          err_next;
  logic                          active_reg;
  logic                          active_next;

  // One masked term per channel; at most one hit, so an OR merges them
  for (genvar i = 0; i < evsel_pkg::NUM_CH; i++) begin : g_ch
    assign hit[i]  = (sel.channel == evsel_pkg::evsel_word_t'(i));
    assign term[i] = hit[i] ? sel.data[i] : evsel_pkg::WORD_ZERO;
  end
  assign pick = sel.data[sel.channel[2:0]];

  // Next values, re-evaluated every clock
  always_comb begin
    active_next = sel.act || !sel.cfg_check;
    err_next    = (sel.channel < evsel_pkg::CH_MIN) ||
                  (sel.channel > evsel_pkg::CH_MAX);
    value_next  = evsel_pkg::WORD_ZERO;
    for (int k = 0; k < evsel_pkg::NUM_CH; k++) begin
      value_next = value_next | term[k];
    end
    if (!active_next || err_next) begin
      value_next = evsel_pkg::WORD_ZERO;
    end
  end

  // Register once per clock so every input change shows one cycle later
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      value_reg  <= 32'h0000_0000;
      err_reg    <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      value_reg  <= value_next;
      err_reg    <= err_next;
      active_reg <= active_next;
    end
  end

  assign sel.value  = value_reg;
  assign sel.err    = err_reg;
  assign sel.active = active_reg;

  // ==========================================================================
  // Checks
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_route_one: assert property ((sel.act || !sel.cfg_check) && sel.channel >= 0 && sel.channel <= 7
    |=> sel.value == $past(pick)) else $error("Selected value not routed");
  a_map_first: assert property (sel.act && sel.channel == 0 |=> sel.value == $past(sel.data[0]))
    else $error("Channel zero does not pick the first input");
  a_follow_chan: assert property (sel.act && $past(sel.act) && $changed(sel.channel)
    && sel.channel >= 0 && sel.channel <= 7 |=> sel.value == $past(pick)) else $error("Channel change missed");
  a_idle_zero: assert property (sel.cfg_check && !sel.act |=> sel.value == 0)
    else $error("Output not zero while inactive");
  a_err_flag: assert property ((sel.channel < 0 || sel.channel > 7) |=> sel.err)
    else $error("Range error not flagged");
  a_err_clear: assert property (sel.channel >= 0 && sel.channel <= 7 |=> !sel.err)
    else $error("Range error flagged in range");
  a_err_zero: assert property (sel.err |-> sel.value == 0)
    else $error("Output not zero on range error");
  a_neg_extreme: assert property (sel.act && sel.channel == 0 && sel.data[0] == 32'h8000_0000
    |=> sel.value == 32'h8000_0000) else $error("Most negative value not carried");
  a_check_off: assert property (!sel.cfg_check && !sel.act && sel.channel == 5
    |=> sel.value == $past(sel.data[5]) && sel.active) else $error("Activation not ignored");
  a_on_level: assert property (sel.cfg_check |=> sel.active == $past(sel.act))
    else $error("Activation level not used");
  // A zero pick after an idle cycle leaves the output unchanged, so it is left out
  a_one_cycle: assert property ($changed(pick) && pick != 0 && sel.act && sel.channel == 2
    |=> $changed(sel.value) && sel.value == $past(pick)) else $error("Output late by more than a cycle");
endmodule
`default_nettype wire

/* File: rtl/evsel_irq.sv */
// Sticky event status with mask and one level interrupt
`default_nettype none
module evsel_irq #(
  parameter int N = 2
) (
  input  wire logic          sys_clk_in,
  input  wire logic          rst_in,
  input  wire logic [N-1:0]  event_in,
  input  wire logic          clr_we_in,
  input  wire logic [N-1:0]  clr_in,
  input  wire logic          mask_we_in,
  input  wire logic [N-1:0]  mask_in,
  output logic      [N-1:0]  stat_out,
  output logic      [N-1:0]  mask_out,
  output logic               irq_out
);
  logic [N-1:0] stat_reg;
  logic [N-1:0] stat_next;
  logic [N-1:0] mask_reg;
  logic [N-1:0] mask_next;

  // An event in the clearing cycle survives: the set is applied last
  always_comb begin
    stat_next = stat_reg;
    mask_next = mask_reg;
    if (clr_we_in) begin
      stat_next = stat_next & ~clr_in;
    end
    stat_next = stat_next | event_in;
    if (mask_we_in) begin
      mask_next = mask_in;
    end
  end

  // Status and mask storage
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      stat_reg <= '0;
      mask_reg <= '0;
    end else begin
      stat_reg <= stat_next;
      mask_reg <= mask_next;
    end
  end

  assign stat_out = stat_reg;
  assign mask_out = mask_reg;
  assign irq_out  = |(stat_reg & mask_reg);  // Level, driven from flops only
endmodule
`default_nettype wire

/* File: rtl/evsel_top.sv */
// Eight-way value selector with AXI4-Lite registers and interrupt
`default_nettype none
// Operation
// - Eight signed data inputs; at most one, picked by channel, reaches the output.
// - Channel 0 picks the first input, 7 the eighth, linearly between.
// - While activated, output carries the input the channel refers to.
// - Channel changes are followed while activation stays high.
// - Inactive block drives output zero regardless of channel or data.
// - Error flag high when channel below zero or above seven, else low.
// - Output held zero while channel is out of range.
// - Output and inputs are full-range signed 32-bit two's-complement values.
// - With activation check on, activation input level decides activity.
// - With activation check off, block is always active, input ignored.
module evsel_top (
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      activation_in,
  input  wire logic [31:0]               channel_in,
  input  wire logic [31:0]               data_in_1,
  input  wire logic [31:0]               data_in_2,
  input  wire logic [31:0]               data_in_3,
  input  wire logic [31:0]               data_in_4,
  input  wire logic [31:0]               data_in_5,
  input  wire logic [31:0]               data_in_6,
  input  wire logic [31:0]               data_in_7,
  input  wire logic [31:0]               data_in_8,
  output logic      [31:0]               selected_value_out,
  output logic                           range_error_flag_out,
  output logic                           irq_out,
  input  wire logic [7:0]                s_axi_awaddr_in,
  input  wire logic                      s_axi_awvalid_in,
  output logic                           s_axi_awready_out,
  input  wire logic [31:0]               s_axi_wdata_in,
  input  wire logic [3:0]                s_axi_wstrb_in,
  input  wire logic                      s_axi_wvalid_in,
  output logic                           s_axi_wready_out,
  output logic      [1:0]                s_axi_bresp_out,
  output logic                           s_axi_bvalid_out,
  input  wire logic                      s_axi_bready_in,
  input  wire logic [7:0]                s_axi_araddr_in,
  input  wire logic                      s_axi_arvalid_in,
  output logic                           s_axi_arready_out,
  output logic      [31:0]               s_axi_rdata_out,
  output logic      [1:0]                s_axi_rresp_out,
  output logic                           s_axi_rvalid_out,
  input  wire logic                      s_axi_rready_in
);
  // ==========================================================================
  // Selector core
  evsel_sel_if sel ();

  logic                           check_reg;
  logic                           check_next;

  assign sel.cfg_check = check_reg;
  assign sel.act       = activation_in;
  assign sel.channel   = channel_in;
  assign sel.data      = {data_in_8, data_in_7, data_in_6, data_in_5,
                          data_in_4, data_in_3, data_in_2, data_in_1};

  evsel_sel_core u_core (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .sel        (sel)
  );

  assign selected_value_out   = sel.value;
  assign range_error_flag_out = sel.err;

  // ==========================================================================
  // Event detection
  logic                           err_prev_reg;
  evsel_pkg::evsel_word_t         val_prev_reg;
  logic [evsel_pkg::IRQ_N-1:0]    irq_event;
  logic [evsel_pkg::IRQ_N-1:0]    irq_stat;
  logic [evsel_pkg::IRQ_N-1:0]    irq_mask;
  logic                           irq_clr_we;
  logic                           irq_mask_we;
  logic [31:0]                    wdata_reg;   // Held write word, also feeds the clear and mask ports
  logic [31:0]                    wdata_next;

  // Only onsets count, so a lasting error raises one event, not a stream
  always_comb begin
    irq_event = '0;
    irq_event[evsel_pkg::IRQ_ERR_BIT] = sel.err && !err_prev_reg;
    irq_event[evsel_pkg::IRQ_CHG_BIT] = sel.value != val_prev_reg;
  end

  // Previous core outputs for edge detection
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      err_prev_reg <= 1'b0;
      val_prev_reg <= 32'h0000_0000;
    end else begin
      err_prev_reg <= sel.err;
      val_prev_reg <= sel.value;
    end
  end

  evsel_irq #(
    .N (evsel_pkg::IRQ_N)
  ) u_irq (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .event_in   (irq_event),
    .clr_we_in  (irq_clr_we),
    .clr_in     (wdata_reg[evsel_pkg::IRQ_N-1:0]),
    .mask_we_in (irq_mask_we),
    .mask_in    (wdata_reg[evsel_pkg::IRQ_N-1:0]),
    .stat_out   (irq_stat),
    .mask_out   (irq_mask),
    .irq_out    (irq_out)
  );

  // ==========================================================================
  // AXI4-Lite write path
  logic                           aw_full_reg;
  logic                           aw_full_next;
  logic [evsel_pkg::ADDR_W-1:0]   awaddr_reg;
  logic [evsel_pkg::ADDR_W-1:0]   awaddr_next;
  logic                           w_full_reg;
  logic                           w_full_next;
  logic [3:0]                     wstrb_reg;
  logic [3:0]                     wstrb_next;
  logic                           bvalid_reg;
  logic                           bvalid_next;
  logic [1:0]                     bresp_reg;
  logic [1:0]                     bresp_next;
  logic                           do_write;
  logic                           wr_known;

  // Address and data are held apart, so they may arrive in either order
  assign s_axi_awready_out = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready_out  = !w_full_reg && !bvalid_reg;
  assign do_write          = aw_full_reg && w_full_reg && !bvalid_reg;

  always_comb begin
    case (awaddr_reg)
      evsel_pkg::OFS_CTRL, evsel_pkg::OFS_STATUS, evsel_pkg::OFS_IRQ_STAT,
      evsel_pkg::OFS_IRQ_MASK, evsel_pkg::OFS_VALUE, evsel_pkg::OFS_CHANNEL: begin
        wr_known = 1'b1;
      end
      default: begin
        wr_known = 1'b0;
      end
    endcase
  end

  // Effects of a write; only byte lane 0 holds live bits
  assign irq_clr_we  = do_write && wstrb_reg[0] && awaddr_reg == evsel_pkg::OFS_IRQ_STAT;
  assign irq_mask_we = do_write && wstrb_reg[0] && awaddr_reg == evsel_pkg::OFS_IRQ_MASK;

  always_comb begin
    aw_full_next = aw_full_reg;
    awaddr_next  = awaddr_reg;
    w_full_next  = w_full_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    check_next   = check_reg;
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_full_next = 1'b1;
      awaddr_next  = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_full_next = 1'b1;
      wdata_next  = s_axi_wdata_in;
      wstrb_next  = s_axi_wstrb_in;
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = wr_known ? evsel_pkg::RESP_OKAY : evsel_pkg::RESP_SLVERR;
      if (wstrb_reg[0] && awaddr_reg == evsel_pkg::OFS_CTRL) begin
        check_next = wdata_reg[evsel_pkg::CTRL_CHECK_BIT];
      end
    end
    if (bvalid_reg && s_axi_bready_in) begin
      bvalid_next = 1'b0;
    end
  end

  // Write path storage
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      aw_full_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
      w_full_reg  <= 1'b0;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      check_reg   <= evsel_pkg::CTRL_CHECK_RST;
    end else begin
      aw_full_reg <= aw_full_next;
      awaddr_reg  <= awaddr_next;
      w_full_reg  <= w_full_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      check_reg   <= check_next;
    end
  end

  assign s_axi_bvalid_out = bvalid_reg;
  assign s_axi_bresp_out  = bresp_reg;

  // ==========================================================================
  // AXI4-Lite read path
  logic                           rvalid_reg;
  logic                           rvalid_next;
  logic [31:0]                    rdata_reg;
  logic [31:0]                    rdata_next;
  logic [1:0]                     rresp_reg;
  logic [1:0]                     rresp_next;
  logic [31:0]                    rd_word;
  logic                           rd_known;

  assign s_axi_arready_out = !rvalid_reg;

  // Read decode; unused bits read as zero, unmapped words answer SLVERR
  always_comb begin
    rd_word  = 32'h0000_0000;
    rd_known = 1'b1;
    case (s_axi_araddr_in)
      evsel_pkg::OFS_CTRL: begin
        rd_word[evsel_pkg::CTRL_CHECK_BIT] = check_reg;
      end
      evsel_pkg::OFS_STATUS: begin
        rd_word[evsel_pkg::STAT_ACTIVE_BIT] = sel.active;
        rd_word[evsel_pkg::STAT_ERR_BIT]    = sel.err;
      end
      evsel_pkg::OFS_IRQ_STAT: begin
        rd_word[evsel_pkg::IRQ_N-1:0] = irq_stat;
      end
      evsel_pkg::OFS_IRQ_MASK: begin
        rd_word[evsel_pkg::IRQ_N-1:0] = irq_mask;
      end
      evsel_pkg::OFS_VALUE: begin
        rd_word = sel.value;
      end
      evsel_pkg::OFS_CHANNEL: begin
        rd_word = channel_in;
      end
      default: begin
        rd_known = 1'b0;
      end
    endcase
  end

  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      rvalid_next = 1'b1;
      rdata_next  = rd_word;
      rresp_next  = rd_known ? evsel_pkg::RESP_OKAY : evsel_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready_in) begin
      rvalid_next = 1'b0;
    end
  end

  // Read path storage
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= 2'h0;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  assign s_axi_rvalid_out = rvalid_reg;
  assign s_axi_rdata_out  = rdata_reg;
  assign s_axi_rresp_out  = rresp_reg;

  // ==========================================================================
  // Checks
  a_ctrl_steers: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !check_reg && !activation_in && channel_in == 32'h0000_0005 |=> selected_value_out == $past(data_in_6))
    else $error("Activation input not ignored at the pins");
  a_flag_pin: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    range_error_flag_out |-> selected_value_out == 32'h0000_0000) else $error("Pin value not zero on error");
endmodule
`default_nettype wire

/* File: verification/evsel_ctl_model.sv */
// Controller-side model that presents activation, channel and values to the selector
`default_nettype none
module evsel_ctl_model (
  input  wire logic                  act_req_in,
  input  wire logic signed [31:0]    ch_req_in,
  input  wire evsel_pkg::evsel_vec_t data_req_in,
  output logic                       activation_out,
  output logic             [31:0]    channel_out,
  output evsel_pkg::evsel_vec_t      data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Program outputs, held for the whole evaluation cycle
  // Channel goes out at full signed width so negative and large values stay visible
  assign channel_out    = ch_req_in;
  assign activation_out = act_req_in;
  assign data_out       = data_req_in;
endmodule
`default_nettype wire

/* File: verification/tb_eight_way_value_selector.sv */
// Self-checking bench for the eight-way value selector
`default_nettype none
module tb_eight_way_value_selector;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic act; logic [31:0] ch; logic [31:0] val; logic err;} evsel_row_t;
  // ==========================================================================
  // Signals
  logic                  clk = 1'b0;
  logic                  rst;
  logic                  act;
  logic signed [31:0]    ch;
  evsel_pkg::evsel_vec_t dv;
  evsel_pkg::evsel_vec_t data;
  logic                  activation, err, irq;
  logic        [31:0]    channel, value, wdata, rdata, d;
  logic        [7:0]     awaddr, araddr;
  logic        [1:0]     bresp, rresp, r;
  logic                  awvalid, wvalid, bready, arvalid, rready;
  logic                  awready, wready, bvalid, arready, rvalid;
  int                    mismatches = 0;
  int                    n_checks = 0;
  int                    cyc = 0;
  evsel_row_t            rows [13];
  // ==========================================================================
  // Clock and instances
  always #4 clk = ~clk;
  evsel_ctl_model evsel_ctl_model_i (.act_req_in(act), .ch_req_in(ch), .data_req_in(dv),
    .activation_out(activation), .channel_out(channel), .data_out(data));
  evsel_top evsel_top_i (.sys_clk_in(clk), .rst_in(rst), .activation_in(activation), .channel_in(channel),
    .data_in_1(data[0]), .data_in_2(data[1]), .data_in_3(data[2]), .data_in_4(data[3]),
    .data_in_5(data[4]), .data_in_6(data[5]), .data_in_7(data[6]), .data_in_8(data[7]),
    .selected_value_out(value), .range_error_flag_out(err), .irq_out(irq),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  // ==========================================================================
  // Reporting
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      close_out();
    end
  end
  // ==========================================================================
  // Bus cycles; each channel is released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    act = 1'b0;
    ch = 0;
    {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    dv = {32'hDEAD_BEEF, 32'h0F0F_F0F0, 32'hA5A5_5A5A, 32'h1234_5678,
          32'hFFFF_FFFF, 32'h0000_0001, 32'h7FFF_FFFF, 32'h8000_0000};
    // Channel sweep: the first eleven rows stay active without deactivating, the last two run inactive
    rows = '{'{1, 0, 32'h8000_0000, 0}, '{1, 1, 32'h7FFF_FFFF, 0}, '{1, 2, 32'h0000_0001, 0},
             '{1, 3, 32'hFFFF_FFFF, 0}, '{1, 4, 32'h1234_5678, 0}, '{1, 5, 32'hA5A5_5A5A, 0},
             '{1, 6, 32'h0F0F_F0F0, 0}, '{1, 7, 32'hDEAD_BEEF, 0}, '{1, 32'hFFFF_FFFF, 0, 1},
             '{1, 8, 0, 1}, '{1, 32'h8000_0000, 0, 1}, '{0, 3, 0, 0}, '{0, 9, 0, 1}};
    repeat (12) @(posedge clk);
    chk("value_in_reset", 32'h0000_0000, value);
    chk("irq_in_reset", 32'h0000_0000, {31'h0, irq});
    rst <= 1'b0;
    rd(evsel_pkg::OFS_CTRL, d, r);
    chk("ctrl_reset", 32'h0000_0001, d);
    rd(evsel_pkg::OFS_IRQ_MASK, d, r);
    chk("mask_reset", 32'h0000_0000, d);
    foreach (rows[i]) begin
      @(posedge clk);
      act <= rows[i].act;
      ch <= rows[i].ch;
      @(posedge clk);
      #1;
      chk("selected_value", rows[i].val, value);
      chk("range_error", {31'h0, rows[i].err}, {31'h0, err});
    end
    // Activation check switched off: inactive input is ignored
    @(posedge clk);
    ch <= 5;
    wr(evsel_pkg::OFS_CTRL, 32'h0000_0000, r);
    @(posedge clk);
    #1;
    chk("value_check_off", dv[5], value);
    rd(evsel_pkg::OFS_STATUS, d, r);
    chk("status_check_off", 32'h0000_0001, d);
    wr(evsel_pkg::OFS_CTRL, 32'h0000_0001, r);
    @(posedge clk);
    #1;
    chk("value_check_on", 32'h0000_0000, value);
    // Error onset interrupt: raise, mask, unmask, clear
    wr(evsel_pkg::OFS_IRQ_STAT, 32'h0000_0003, r);
    wr(evsel_pkg::OFS_IRQ_MASK, 32'h0000_0001, r);
    @(posedge clk);
    ch <= 9;
    for (int i = 0; i < 4 && irq !== 1'b1; i++) @(posedge clk);
    #1;
    chk("irq_on_error", 32'h0000_0001, {31'h0, irq});
    rd(evsel_pkg::OFS_STATUS, d, r);
    chk("status_error", 32'h0000_0002, d);
    wr(evsel_pkg::OFS_IRQ_MASK, 32'h0000_0000, r);
    #1;
    chk("irq_masked", 32'h0000_0000, {31'h0, irq});
    wr(evsel_pkg::OFS_IRQ_MASK, 32'h0000_0001, r);
    #1;
    chk("irq_unmasked", 32'h0000_0001, {31'h0, irq});
    @(posedge clk);
    act <= 1'b1;
    ch <= 4;
    wr(evsel_pkg::OFS_IRQ_STAT, 32'h0000_0001, r);
    #1;
    chk("irq_cleared", 32'h0000_0000, {31'h0, irq});
    rd(evsel_pkg::OFS_IRQ_STAT, d, r);
    chk("irq_stat_change", 32'h0000_0002, d);
    // Unmapped and read-only places
    wr(8'h20, 32'h0000_0001, r);
    chk("unmapped_bresp", {30'h0, evsel_pkg::RESP_SLVERR}, {30'h0, r});
    rd(8'h20, d, r);
    chk("unmapped_rresp", {30'h0, evsel_pkg::RESP_SLVERR}, {30'h0, r});
    chk("unmapped_rdata", 32'h0000_0000, d);
    wr(evsel_pkg::OFS_VALUE, 32'h0000_0005, r);
    chk("ro_bresp", {30'h0, evsel_pkg::RESP_OKAY}, {30'h0, r});
    rd(evsel_pkg::OFS_VALUE, d, r);
    chk("value_reg", dv[4], d);
    rd(evsel_pkg::OFS_CHANNEL, d, r);
    chk("channel_reg", 32'h0000_0004, d);
    close_out();
  end
endmodule
`default_nettype wire
